/* File: hw/iscr_pkg.sv */
// Constants, types and register map of the system control register bank.
// Assumes a 100 MHz unit clock and config-space accesses of whole dwords.
package iscr_pkg;

  // Configuration functions that own the registers
  localparam logic [2:0] FUNC_SYSCTL = 3'h2;
  localparam logic [2:0] FUNC_MISC = 3'h3;

  // Register offsets in config space
  localparam logic [7:0] OFS_ERROR_EVENT_MAP = 8'h80;
  localparam logic [7:0] OFS_MACHINE_CHECK_TRIGGER = 8'hC4;
  localparam logic [7:0] OFS_RESET_CONTROL = 8'hCC;
  localparam logic [7:0] OFS_SLEEP_COUNT_LOW = 8'h64;
  localparam logic [7:0] OFS_SLEEP_COUNT_HIGH = 8'h68;
  localparam logic [7:0] OFS_POWER_STATE_FLAGS = 8'hD8;
  localparam logic [7:0] OFS_THROTTLE_STATUS = 8'hF0;
  localparam logic [7:0] OFS_THROTTLE_CONTROL = 8'hF4;

  // Field positions
  localparam int SEV0_LSB = 0;
  localparam int SEV1_LSB = 4;
  localparam int MC_TRIGGER_BIT = 0;
  localparam int RESET_REQ_BIT = 10;
  localparam int RESET_MASK_BIT = 11;
  localparam int PSF_RUN_ACK_BIT = 0;
  localparam int PSF_RUN_REQ_BIT = 1;
  localparam int PSF_HUB_ACK_LSB = 8;
  localparam int PSF_REQ_SENT_LSB = 11;
  localparam int PSF_L1_BIT = 14;
  localparam int THR_EVENT_BIT = 1;
  localparam int THR_COH_EN_BIT = 2;
  localparam int THR_L0S_EN_BIT = 3;
  localparam int SLEEP_HIGH_W = 12;
  localparam int SLEEP_W = 44;

  // Event map encodings and reset values
  localparam logic [2:0] MAP_NMI = 3'h2;
  localparam logic [2:0] MAP_SMI = 3'h1;
  localparam logic [2:0] MAP_RESET = 3'h2;
  localparam logic [1:0] THR_CTRL_RESET = 2'h3;
  localparam logic [SLEEP_W-1:0] SLEEP_RESET = 44'h0;

  // Internal reset hold time
  localparam int CLK_PERIOD_NS = 10;
  localparam int INT_RESET_TIME_NS = 160;
  localparam int INT_RESET_CYCLES_I = (INT_RESET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [11:0] INT_RESET_CYCLES = 12'(INT_RESET_CYCLES_I);

  typedef enum logic [1:0] {
    RST_IDLE = 2'b00,
    RST_WAIT_CPL = 2'b01,
    RST_HOLD = 2'b10
  } iscr_rst_state_e;

  // One config access, held until acknowledged
  typedef struct packed {
    logic valid;
    logic write;
    logic [2:0] func;
    logic [7:0] addr;
    logic [31:0] wdata;
  } iscr_cfg_req_s;

  // Power management message events, one-cycle pulses
  typedef struct packed {
    logic l1_entered;
    logic [2:0] req_sent;
    logic [2:0] hub_ack;
    logic run_req_seen;
    logic run_ack_seen;
  } iscr_pwr_evt_s;

endpackage : iscr_pkg

/* File: hw/iscr_regs.sv */
// System control and status register bank of the integrated I/O unit.
// Assumes synchronous inputs, rst as power-good reset and a separate hard reset pin.
// Function
// - Severity-0 map bits 2:0: 010 NMI, 001 SMI, 000 nothing; sticky, default 010.
// - Machine-check trigger bit 0 rising from 0 to 1 dispatches a machine-check request.
// - Trigger bit clears itself once the coherent link reports the dispatch.
// - Resets from reset control writes wait until the config write has completed.
// - Mask bit 11 clear: follow hard reset input; set: ignore hard reset input.
// - Writing 1 to bit 10 asserts internal reset; bit clears when timer expires.
// - Sleep counter zeroes on sleep entry, then counts each asleep clock.
// - Low sleep count register reads counter bits 31:0.
// - High sleep count register reads counter bits 43:32 in 11:0, rest zero.
// - Flag bit 14 sets when the coherent link enters L1.
// - Flag bits 13, 12, 11 set on sent C7, C6, C3 requests.
// - Flag bits 10, 9, 8 set when hub acknowledges C7, C6, C3.
// - Flag bit 1 sets on run-state request, clears on next C3/C6/C7 request.
// - Flag bit 0 sets when hub returns the run-state acknowledge.
// - Throttle status bit 1 sets on high temperature; sticky, write 1 clears.
// - Control bit 3, default 1, forces PCIe transmit links to L0s while throttling.
// - Control bit 2, default 1, throttles the coherent link while throttling.
`timescale 1ns/1ps
`default_nettype none

module iscr_regs (
  // Clock and power-good reset
  input wire logic clk,
  input wire logic rst,
  // Hard reset pin, active low
  input wire logic hard_reset_in_n,
  // Configuration access
  input wire iscr_pkg::iscr_cfg_req_s cfg_req,
  output logic cfg_ack,
  output logic [31:0] cfg_rdata,
  // Error severities and system events
  input wire logic sev0_error,
  input wire logic sev1_error,
  output logic nmi_event,
  output logic smi_event,
  // Machine-check path
  input wire logic mc_dispatched,
  output logic mc_request,
  // Unit reset
  output logic unit_reset,
  // Sleep and power messages
  input wire logic sleep_active,
  input wire iscr_pkg::iscr_pwr_evt_s pwr_evt,
  // Thermal throttling
  input wire logic thermal_event,
  output logic pcie_force_l0s,
  output logic coherent_throttle
);
  import iscr_pkg::*;

  // Sticky state, cleared only by rst
  logic [2:0] sev0_map_reg;
  logic [2:0] sev1_map_reg;
  logic mc_trigger_reg;
  logic [SLEEP_W-1:0] sleep_cnt_reg;
  logic sleep_prev_reg;
  logic [15:0] psf_reg;
  logic thr_event_reg;
  // Non-sticky state, also cleared by hard reset
  logic reset_mask_reg;
  logic reset_req_reg;
  logic [1:0] thr_ctrl_reg;
  iscr_rst_state_e rst_state_reg;
  logic [11:0] rst_cnt_reg;
  // Outputs from flops
  logic cfg_ack_reg;
  logic [31:0] cfg_rdata_reg;
  logic nmi_reg;
  logic smi_reg;
  logic unit_reset_reg;
  logic l0s_reg;
  logic coh_thr_reg;

  // Access decode
  // The ack cycle blocks a second take of a request that is still held,
  // so a requester must drop valid for one cycle between accesses
  wire take = cfg_req.valid & ~cfg_ack_reg;
  wire wr = take & cfg_req.write;
  wire f2 = cfg_req.func == FUNC_SYSCTL;
  wire f3 = cfg_req.func == FUNC_MISC;
  wire hit_map = f2 && cfg_req.addr == OFS_ERROR_EVENT_MAP;
  wire hit_mc = f2 && cfg_req.addr == OFS_MACHINE_CHECK_TRIGGER;
  wire hit_rc = f2 && cfg_req.addr == OFS_RESET_CONTROL;
  wire hit_slo = f3 && cfg_req.addr == OFS_SLEEP_COUNT_LOW;
  wire hit_shi = f3 && cfg_req.addr == OFS_SLEEP_COUNT_HIGH;
  wire hit_psf = f3 && cfg_req.addr == OFS_POWER_STATE_FLAGS;
  wire hit_tst = f3 && cfg_req.addr == OFS_THROTTLE_STATUS;
  wire hit_tct = f3 && cfg_req.addr == OFS_THROTTLE_CONTROL;
  wire wr_map = wr & hit_map;
  wire wr_mc = wr & hit_mc;
  wire wr_rc = wr & hit_rc;
  wire wr_tst = wr & hit_tst;
  wire wr_tct = wr & hit_tct;

  // Hard reset only acts while not masked
  wire hard_rst = ~hard_reset_in_n & ~reset_mask_reg;

  // Event map
  wire nmi_next = (sev0_error & (sev0_map_reg == MAP_NMI))
    | (sev1_error & (sev1_map_reg == MAP_NMI));
  wire smi_next = (sev0_error & (sev0_map_reg == MAP_SMI))
    | (sev1_error & (sev1_map_reg == MAP_SMI));

  // Machine check: a write of 1 over 0 is the rising edge that requests.
  // A dispatch in the same cycle as a new rising write does not cancel it.
  wire mc_rise = wr_mc & cfg_req.wdata[MC_TRIGGER_BIT] & ~mc_trigger_reg;
  wire mc_next = mc_rise ? 1'b1
    : (mc_dispatched & mc_trigger_reg) ? 1'b0
    : wr_mc ? cfg_req.wdata[MC_TRIGGER_BIT]
    : mc_trigger_reg;

  // Sleep counter
  wire sleep_entry = sleep_active & ~sleep_prev_reg;
  wire [SLEEP_W-1:0] sleep_next = sleep_entry ? SLEEP_RESET
    : sleep_active ? sleep_cnt_reg + 44'h1
    : sleep_cnt_reg;

  // Power state flags
  // Bits are driven one by one, so this is a net rather than a variable
  wire [15:0] psf_set;
  logic [15:0] psf_clr;
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_cstate
      assign psf_set[PSF_REQ_SENT_LSB+gi] = pwr_evt.req_sent[gi];
      assign psf_set[PSF_HUB_ACK_LSB+gi] = pwr_evt.hub_ack[gi];
    end
  endgenerate
  assign psf_set[PSF_L1_BIT] = pwr_evt.l1_entered;
  assign psf_set[PSF_RUN_REQ_BIT] = pwr_evt.run_req_seen;
  assign psf_set[PSF_RUN_ACK_BIT] = pwr_evt.run_ack_seen;
  assign psf_set[15] = 1'b0;
  assign psf_set[7:2] = 6'h0;
  always_comb
  begin
    psf_clr = 16'h0;
    psf_clr[PSF_RUN_REQ_BIT] = |pwr_evt.req_sent;
  end
  // Set wins over clear
  wire [15:0] psf_next = (psf_reg & ~psf_clr) | psf_set;

  // Throttling: sticky event, write-1 clear loses to a new event
  wire thr_clr = wr_tst & cfg_req.wdata[THR_EVENT_BIT];
  wire thr_next = thermal_event | (thr_event_reg & ~thr_clr);

  // Internal reset sequencer
  wire req_written = wr_rc & cfg_req.wdata[RESET_REQ_BIT];
  iscr_rst_state_e rst_state_next;
  logic [11:0] rst_cnt_next;
  logic req_done;
  always_comb
  begin
    rst_state_next = rst_state_reg;
    rst_cnt_next = rst_cnt_reg;
    req_done = 1'b0;
    case (rst_state_reg)
      RST_IDLE:
      begin
        if (req_written)
          rst_state_next = RST_WAIT_CPL;
      end
      RST_WAIT_CPL:
      begin
        // The requester drops valid once it has seen the ack
        if (~cfg_req.valid)
        begin
          rst_state_next = RST_HOLD;
          rst_cnt_next = INT_RESET_CYCLES;
        end
      end
      RST_HOLD:
      begin
        if (rst_cnt_reg <= 12'h1)
        begin
          // A new request in the last hold cycle starts over instead of being lost
          if (req_written)
            rst_state_next = RST_WAIT_CPL;
          else
          begin
            rst_state_next = RST_IDLE;
            req_done = 1'b1;
          end
        end
        else
          rst_cnt_next = rst_cnt_reg - 12'h1;
      end
      default:
        rst_state_next = RST_IDLE;
    endcase
  end

  wire rc_req_next = req_done ? 1'b0
    : req_written ? 1'b1
    : reset_req_reg;
  wire rc_mask_next = wr_rc ? cfg_req.wdata[RESET_MASK_BIT] : reset_mask_reg;
  wire [1:0] tct_next = wr_tct ? cfg_req.wdata[THR_L0S_EN_BIT:THR_COH_EN_BIT]
    : thr_ctrl_reg;
  wire unit_reset_next = (rst_state_next == RST_HOLD) | hard_rst;

  // Read data
  logic [31:0] rd;
  always_comb
  begin
    rd = 32'h0;
    if (hit_map)
    begin
      rd[SEV0_LSB+:3] = sev0_map_reg;
      rd[SEV1_LSB+:3] = sev1_map_reg;
    end
    else if (hit_mc)
      rd[MC_TRIGGER_BIT] = mc_trigger_reg;
    else if (hit_rc)
    begin
      rd[RESET_MASK_BIT] = reset_mask_reg;
      rd[RESET_REQ_BIT] = reset_req_reg;
    end
    else if (hit_slo)
      rd = sleep_cnt_reg[31:0];
    else if (hit_shi)
      rd[SLEEP_HIGH_W-1:0] = sleep_cnt_reg[SLEEP_W-1:32];
    else if (hit_psf)
      rd[15:0] = psf_reg;
    else if (hit_tst)
      rd[THR_EVENT_BIT] = thr_event_reg;
    else if (hit_tct)
      rd[THR_L0S_EN_BIT:THR_COH_EN_BIT] = thr_ctrl_reg;
  end

  // Sticky flops see only power-good reset
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sev0_map_reg <= MAP_RESET;
      sev1_map_reg <= MAP_RESET;
      mc_trigger_reg <= 1'b0;
      sleep_cnt_reg <= SLEEP_RESET;
      sleep_prev_reg <= 1'b0;
      psf_reg <= 16'h0;
      thr_event_reg <= 1'b0;
    end
    else
    begin
      if (wr_map)
      begin
        sev0_map_reg <= cfg_req.wdata[SEV0_LSB+:3];
        sev1_map_reg <= cfg_req.wdata[SEV1_LSB+:3];
      end
      mc_trigger_reg <= mc_next;
      sleep_cnt_reg <= sleep_next;
      sleep_prev_reg <= sleep_active;
      psf_reg <= psf_next;
      thr_event_reg <= thr_next;
    end
  end

  // Non-sticky control returns to defaults on an unmasked hard reset
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      reset_mask_reg <= 1'b0;
      reset_req_reg <= 1'b0;
      thr_ctrl_reg <= THR_CTRL_RESET;
      rst_state_reg <= RST_IDLE;
      rst_cnt_reg <= 12'h0;
    end
    else if (hard_rst)
    begin
      reset_mask_reg <= 1'b0;
      reset_req_reg <= 1'b0;
      thr_ctrl_reg <= THR_CTRL_RESET;
      rst_state_reg <= RST_IDLE;
      rst_cnt_reg <= 12'h0;
    end
    else
    begin
      reset_mask_reg <= rc_mask_next;
      reset_req_reg <= rc_req_next;
      thr_ctrl_reg <= tct_next;
      rst_state_reg <= rst_state_next;
      rst_cnt_reg <= rst_cnt_next;
    end
  end

  // Output flops
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cfg_ack_reg <= 1'b0;
      cfg_rdata_reg <= 32'h0;
      nmi_reg <= 1'b0;
      smi_reg <= 1'b0;
      unit_reset_reg <= 1'b0;
      l0s_reg <= 1'b0;
      coh_thr_reg <= 1'b0;
    end
    else
    begin
      cfg_ack_reg <= take;
      if (take)
        cfg_rdata_reg <= rd;
      nmi_reg <= nmi_next;
      smi_reg <= smi_next;
      unit_reset_reg <= unit_reset_next;
      l0s_reg <= thermal_event & thr_ctrl_reg[1];
      coh_thr_reg <= thermal_event & thr_ctrl_reg[0];
    end
  end

  assign cfg_ack = cfg_ack_reg;
  assign cfg_rdata = cfg_rdata_reg;
  assign nmi_event = nmi_reg;
  assign smi_event = smi_reg;
  assign mc_request = mc_trigger_reg;
  assign unit_reset = unit_reset_reg;
  assign pcie_force_l0s = l0s_reg;
  assign coherent_throttle = coh_thr_reg;

endmodule : iscr_regs

`default_nettype wire

/* File: test/iscr_regs_properties.sv */
// Port-level checker for the system control register bank.
// Bound to every iscr_regs instance; sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module iscr_regs_properties
  import iscr_pkg::*;
(
  // Clock and power-good reset
  input wire logic clk,
  input wire logic rst,
  // Reset pin and config access
  input wire logic hard_reset_in_n,
  input wire iscr_pkg::iscr_cfg_req_s cfg_req,
  input wire logic cfg_ack,
  input wire logic [31:0] cfg_rdata,
  // Events and machine check
  input wire logic sev0_error,
  input wire logic sev1_error,
  input wire logic nmi_event,
  input wire logic smi_event,
  input wire logic mc_dispatched,
  input wire logic mc_request,
  // Unit reset, sleep, power and thermal
  input wire logic unit_reset,
  input wire logic sleep_active,
  input wire iscr_pkg::iscr_pwr_evt_s pwr_evt,
  input wire logic thermal_event,
  input wire logic pcie_force_l0s,
  input wire logic coherent_throttle
);
  logic [11:0] run_cnt_reg;
  logic hard_seen_reg;
  // Pin-driven resets have no fixed length, so only internal ones are timed
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      run_cnt_reg <= 12'h000;
      hard_seen_reg <= 1'b0;
    end
    else
    begin
      run_cnt_reg <= unit_reset ? run_cnt_reg + 12'h001 : 12'h000;
      hard_seen_reg <= (unit_reset & hard_seen_reg) | ~hard_reset_in_n;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  property p_ack; cfg_req.valid && !cfg_ack |=> cfg_ack; endproperty
  a_ack: assert property (p_ack) else $error("request not acked");
  property p_ack_pulse; cfg_ack |=> !cfg_ack; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_event; nmi_event || smi_event |-> $past(sev0_error || sev1_error); endproperty
  a_event: assert property (p_event) else $error("event without error");
  property p_mc_set;
    $rose(mc_request) |-> cfg_ack && cfg_req.write && cfg_req.addr == OFS_MACHINE_CHECK_TRIGGER;
  endproperty
  a_mc_set: assert property (p_mc_set) else $error("machine check without write");
  property p_mc_clr; mc_request && mc_dispatched && !cfg_req.valid |=> !mc_request; endproperty
  a_mc_clr: assert property (p_mc_clr) else $error("trigger not cleared");
  property p_rst_wait;
    $rose(unit_reset) |-> !$past(cfg_req.valid) || !$past(hard_reset_in_n);
  endproperty
  a_rst_wait: assert property (p_rst_wait) else $error("reset before write done");
  property p_rst_len; $fell(unit_reset) && !hard_seen_reg |-> run_cnt_reg == INT_RESET_CYCLES;
  endproperty
  a_rst_len: assert property (p_rst_len) else $error("internal reset length");
  property p_l0s; pcie_force_l0s |-> $past(thermal_event); endproperty
  a_l0s: assert property (p_l0s) else $error("l0s without event");
  property p_coh; coherent_throttle |-> $past(thermal_event); endproperty
  a_coh: assert property (p_coh) else $error("throttle without event");
  c_nmi: cover property (nmi_event);
  c_mc: cover property (mc_request && mc_dispatched);
  c_rst: cover property ($fell(unit_reset) && !hard_seen_reg);
endmodule : iscr_regs_properties
bind iscr_regs iscr_regs_properties chk_u (.clk(clk), .rst(rst),
  .hard_reset_in_n(hard_reset_in_n), .cfg_req(cfg_req), .cfg_ack(cfg_ack),
  .cfg_rdata(cfg_rdata), .sev0_error(sev0_error), .sev1_error(sev1_error),
  .nmi_event(nmi_event), .smi_event(smi_event), .mc_dispatched(mc_dispatched),
  .mc_request(mc_request), .unit_reset(unit_reset), .sleep_active(sleep_active),
  .pwr_evt(pwr_evt), .thermal_event(thermal_event), .pcie_force_l0s(pcie_force_l0s),
  .coherent_throttle(coherent_throttle));
`default_nettype wire

/* File: test/iscr_regs_tb_top.sv */
// Self-checking bench for the system control register bank.
// Drives every port itself, config accesses through read and write tasks.
`timescale 1ns/1ps
`default_nettype none
module iscr_regs_tb_top;
  import iscr_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic hard_reset_in_n = 1'b1;
  iscr_cfg_req_s cfg_req = '0;
  iscr_pwr_evt_s pwr_evt = '0;
  logic sev0_error = 1'b0, sev1_error = 1'b0, mc_dispatched = 1'b0;
  logic sleep_active = 1'b0, thermal_event = 1'b0;
  logic cfg_ack, nmi_event, smi_event, mc_request, unit_reset, pcie_force_l0s, coherent_throttle;
  logic [31:0] cfg_rdata;
  logic [31:0] rdv;
  int fail_count = 0;
  int comparisons = 0;
  int cnt;
  logic [7:0] ra [9] = '{OFS_ERROR_EVENT_MAP, OFS_MACHINE_CHECK_TRIGGER, OFS_RESET_CONTROL,
    OFS_SLEEP_COUNT_LOW, OFS_SLEEP_COUNT_HIGH, OFS_POWER_STATE_FLAGS, OFS_THROTTLE_STATUS,
    OFS_THROTTLE_CONTROL, 8'h10};
  logic [31:0] re [9] = '{{25'h0, MAP_RESET, 1'b0, MAP_RESET}, 32'h0, 32'h0, 32'h0, 32'h0,
    32'h0, 32'h0, {28'h0, THR_CTRL_RESET, 2'h0}, 32'h0};

  initial forever #5 clk = ~clk;

  iscr_regs dut_u (.clk(clk), .rst(rst), .hard_reset_in_n(hard_reset_in_n),
    .cfg_req(cfg_req), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata), .sev0_error(sev0_error),
    .sev1_error(sev1_error), .nmi_event(nmi_event), .smi_event(smi_event),
    .mc_dispatched(mc_dispatched), .mc_request(mc_request), .unit_reset(unit_reset),
    .sleep_active(sleep_active), .pwr_evt(pwr_evt), .thermal_event(thermal_event),
    .pcie_force_l0s(pcie_force_l0s), .coherent_throttle(coherent_throttle));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  // Valid drops at the ack edge, so the next call leaves the one-cycle gap
  task automatic acc(input logic w, input logic [2:0] f, input logic [7:0] a,
    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cfg_req <= '{1'b1, w, f, a, d};
    do
    begin
      @(posedge clk);
      n++;
    end
    while (cfg_ack !== 1'b1 && n < 10);
    if (cfg_ack !== 1'b1)
    begin
      fail_count++;
      $display("[ERR] %0t access not acknowledged", $time);
    end
    rdv = cfg_rdata;
    cfg_req.valid <= 1'b0;
  endtask : acc

  task automatic rd(input logic [2:0] f, input logic [7:0] a, input logic [31:0] e);
    acc(1'b0, f, a, 32'h0);
    chk(rdv, e, "read");
  endtask : rd

  task automatic pw(input iscr_pwr_evt_s v, input logic [31:0] e);
    @(posedge clk);
    pwr_evt <= v;
    @(posedge clk);
    pwr_evt <= '0;
    rd(FUNC_MISC, OFS_POWER_STATE_FLAGS, e);
  endtask : pw

  task automatic hr(input logic e);
    @(posedge clk);
    hard_reset_in_n <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk(32'(unit_reset), 32'(e), "pin reset");
    @(posedge clk);
    hard_reset_in_n <= 1'b1;
    repeat (3) @(posedge clk);
  endtask : hr

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop

  initial
  begin
    #50us;
    fail_count++;
    $display("[ERR] %0t watchdog expired", $time);
    report_and_stop();
  end

  initial
  begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 9; i++)
      rd((i < 3 || i == 8) ? FUNC_SYSCTL : FUNC_MISC, ra[i], re[i]);
    acc(1'b1, FUNC_SYSCTL, 8'h10, 32'hFFFFFFFF);
    rd(FUNC_SYSCTL, 8'h10, 32'h0);
    acc(1'b1, FUNC_MISC, OFS_SLEEP_COUNT_HIGH, 32'hFFFFFFFF);
    rd(FUNC_MISC, OFS_SLEEP_COUNT_HIGH, 32'h0);
    $display("test defaults done");
    for (int c = 0; c < 3; c++)
    begin
      acc(1'b1, FUNC_SYSCTL, OFS_ERROR_EVENT_MAP, 32'(c));
      @(posedge clk);
      sev0_error <= 1'b1;
      @(posedge clk);
      sev0_error <= 1'b0;
      #1;
      chk({smi_event, nmi_event}, {3'(c) == MAP_SMI, 3'(c) == MAP_NMI}, "map");
    end
    acc(1'b1, FUNC_SYSCTL, OFS_ERROR_EVENT_MAP, 32'h12);
    @(posedge clk);
    sev1_error <= 1'b1;
    @(posedge clk);
    sev1_error <= 1'b0;
    #1;
    chk({smi_event, nmi_event}, 32'h2, "map sev1");
    $display("test map done");
    @(posedge clk);
    thermal_event <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk({pcie_force_l0s, coherent_throttle}, 32'h3, "throttle");
    acc(1'b1, FUNC_MISC, OFS_THROTTLE_CONTROL, 32'h4);
    repeat (2) @(posedge clk);
    #1;
    chk({pcie_force_l0s, coherent_throttle}, 32'h1, "throttle en");
    @(posedge clk);
    thermal_event <= 1'b0;
    acc(1'b1, FUNC_MISC, OFS_THROTTLE_STATUS, 32'h0);
    rd(FUNC_MISC, OFS_THROTTLE_STATUS, 32'h2);
    acc(1'b1, FUNC_MISC, OFS_THROTTLE_STATUS, 32'h2);
    rd(FUNC_MISC, OFS_THROTTLE_STATUS, 32'h0);
    $display("test throttle done");
    // Firmware never sets the trigger; only this scenario does, to prove the path
    acc(1'b1, FUNC_SYSCTL, OFS_MACHINE_CHECK_TRIGGER, 32'h1);
    #1;
    chk(32'(mc_request), 32'h1, "mc set");
    @(posedge clk);
    mc_dispatched <= 1'b1;
    @(posedge clk);
    mc_dispatched <= 1'b0;
    #1;
    chk(32'(mc_request), 32'h0, "mc clear");
    rd(FUNC_SYSCTL, OFS_MACHINE_CHECK_TRIGGER, 32'h0);
    $display("test machine check done");
    // The second, shorter sleep proves the count restarts from zero
    for (int k = 10; k > 0; k -= 6)
    begin
      @(posedge clk);
      sleep_active <= 1'b1;
      repeat (k) @(posedge clk);
      sleep_active <= 1'b0;
      rd(FUNC_MISC, OFS_SLEEP_COUNT_LOW, 32'(k - 1));
    end
    rd(FUNC_MISC, OFS_SLEEP_COUNT_HIGH, 32'h0);
    $display("test sleep done");
    pw(9'h003, 32'h0003);
    pw(9'h130, 32'h4C01);
    pw(9'h0EC, 32'h7F01);
    $display("test power flags done");
    hr(1'b1);
    rd(FUNC_MISC, OFS_THROTTLE_CONTROL, 32'hC);
    rd(FUNC_SYSCTL, OFS_ERROR_EVENT_MAP, 32'h12);
    rd(FUNC_MISC, OFS_POWER_STATE_FLAGS, 32'h7F01);
    rd(FUNC_MISC, OFS_SLEEP_COUNT_LOW, 32'h3);
    acc(1'b1, FUNC_SYSCTL, OFS_RESET_CONTROL, 32'h800);
    rd(FUNC_SYSCTL, OFS_RESET_CONTROL, 32'h800);
    acc(1'b1, FUNC_MISC, OFS_THROTTLE_CONTROL, 32'h0);
    hr(1'b0);
    rd(FUNC_MISC, OFS_THROTTLE_CONTROL, 32'h0);
    $display("test pin reset done");
    acc(1'b1, FUNC_SYSCTL, OFS_RESET_CONTROL, 32'h400);
    for (int w = 0; w < 5 && unit_reset !== 1'b1; w++)
      @(posedge clk);
    cnt = 0;
    while (unit_reset === 1'b1 && cnt < 100)
    begin
      @(posedge clk);
      cnt++;
    end
    chk(32'(cnt), 32'(INT_RESET_CYCLES), "reset length");
    rd(FUNC_SYSCTL, OFS_RESET_CONTROL, 32'h0);
    $display("test internal reset done");
    report_and_stop();
  end
endmodule : iscr_regs_tb_top
`default_nettype wire
